// File: dv/mcr_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_core_tb
  import mcr_pkg::*;
;
  // ****************************************************
  // Clock, reset and bus signals
  // ****************************************************
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_awaddr = 8'h00;
  logic s_awvalid = 1'b0;
  logic s_awready;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'hF;
  logic s_wvalid = 1'b0;
  logic s_wready;
  logic [1:0] s_bresp;
  logic s_bvalid;
  logic s_bready = 1'b0;
  logic [7:0] s_araddr = 8'h00;
  logic s_arvalid = 1'b0;
  logic s_arready;
  logic [31:0] s_rdata;
  logic [1:0] s_rresp;
  logic s_rvalid;
  logic s_rready = 1'b0;
  logic ext_irq_n = 1'b1;
  logic irq_pending;
  mcr_region_t mem_region;
  logic [1:0] resp;
  logic [31:0] rdat;
  int mismatches = 0;
  int checks = 0;

  always #12.5 mclk = ~mclk;

  mcr_core u_dut (
    .mclk(mclk), .rst(rst),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .ext_irq_n(ext_irq_n), .irq_pending(irq_pending), .mem_region(mem_region)
  );

  // ****************************************************
  // Bus and compare helpers
  // ****************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    int n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    @(posedge mclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_awvalid && s_awready)
      begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok && s_bvalid) && n < 50);
    resp = s_bresp;
    s_bready <= 1'b0;
    if (n >= 50)
      chk(32'h0, 32'h1, "write timeout");
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_arvalid && s_arready)
        s_arvalid <= 1'b0;
    end while (!(s_rvalid && !s_arvalid) && n < 50);
    rdat = s_rdata;
    resp = s_rresp;
    s_rready <= 1'b0;
    if (n >= 50)
      chk(32'h0, 32'h1, "read timeout");
  endtask : rd

  task automatic op(input logic [3:0] code);
    wr(OFF_OP, {28'h0, code});
  endtask : op

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_reset();
    rd(OFF_STK);
    chk(rdat, 32'h00FF, "stack after reset");
    rd(OFF_CCR);
    chk(rdat, 32'h08, "flags after reset");
    rd(OFF_OPT);
    chk(rdat, 32'h02, "option after reset");
  endtask : t_reset

  task automatic t_irq();
    ext_irq_n <= 1'b0;
    repeat (5) @(posedge mclk);
    ext_irq_n <= 1'b1;
    repeat (5) @(negedge mclk);
    chk({31'h0, irq_pending}, 32'h0, "masked irq");
    op(OP_CLI);
    @(negedge mclk);
    chk({31'h0, irq_pending}, 32'h1, "latched irq");
    op(OP_INTR);
    @(negedge mclk);
    chk({31'h0, irq_pending}, 32'h0, "irq taken");
    rd(OFF_CCR);
    chk({31'h0, rdat[FLG_I]}, 32'h1, "mask set by entry");
    op(OP_CLI);
    @(negedge mclk);
    chk({31'h0, irq_pending}, 32'h0, "acked irq gone");
    op(OP_SEI);
    rd(OFF_CCR);
    chk({31'h0, rdat[FLG_I]}, 32'h1, "mask set by op");
  endtask : t_irq

  task automatic t_regs();
    wr(OFF_ACC, 32'h1A5);
    rd(OFF_ACC);
    chk(rdat, 32'hA5, "acc width");
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, "read response");
    wr(OFF_IP, 32'hFFFF);
    rd(OFF_IP);
    chk(rdat, 32'h3FFF, "ip width");
    wr(OFF_IDX, 32'h50);
    op(OP_IDX);
    rd(OFF_MADR);
    chk(rdat, 32'h50, "indexed address");
    wr(8'h40, 32'h1);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
    rd(8'h40);
    chk(rdat, 32'h0, "unmapped read");
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped read response");
  endtask : t_regs

  task automatic t_alu();
    logic [3:0] c [11] = '{OP_ADD, OP_ADD, OP_ADC, OP_ADD, OP_SUB, OP_SUB, OP_AND,
      OP_LSL, OP_ROR, OP_BTST, OP_BTST};
    logic [7:0] a [11] = '{8'h08, 8'h80, 8'h01, 8'h7F, 8'h05, 8'h00, 8'hF0, 8'h81, 8'h02,
      8'h20, 8'h20};
    logic [7:0] x [11] = '{8'h08, 8'h80, 8'h0E, 8'h01, 8'h05, 8'h01, 8'h0F, 8'h00, 8'h00,
      8'h05, 8'h04};
    logic [7:0] r [11] = '{8'h10, 8'h00, 8'h10, 8'h80, 8'h00, 8'hFF, 8'h00, 8'h02, 8'h81,
      8'h20, 8'h20};
    logic [4:0] f [11] = '{5'h10, 5'h03, 5'h10, 5'h14, 5'h02, 5'h05, 5'h03, 5'h01, 5'h04,
      5'h01, 5'h00};
    logic [4:0] m [11] = '{5'h17, 5'h17, 5'h17, 5'h17, 5'h07, 5'h07, 5'h07, 5'h07, 5'h07,
      5'h01, 5'h01};
    for (int i = 0; i < 11; i++)
    begin
      wr(OFF_ACC, {24'h0, a[i]});
      wr(OFF_IDX, {24'h0, x[i]});
      op(c[i]);
      rd(OFF_ACC);
      chk(rdat, {24'h0, r[i]}, "alu result");
      rd(OFF_CCR);
      chk({27'h0, rdat[4:0] & m[i]}, {27'h0, f[i]}, "alu flags");
    end
  endtask : t_alu

  task automatic t_stack();
    op(OP_STK_INIT);
    op(OP_CALL);
    rd(OFF_STK);
    chk(rdat, 32'h00FD, "call push");
    op(OP_INTR);
    rd(OFF_STK);
    chk(rdat, 32'h00F8, "interrupt push");
    wr(OFF_STK, 32'h0);
    rd(OFF_STK);
    chk(rdat, 32'h00C0, "stack floor");
    op(OP_STK_INIT);
    rd(OFF_STK);
    chk(rdat, 32'h00FF, "stack reinit");
    repeat (32) op(OP_CALL);
    rd(OFF_STK);
    chk(rdat, 32'h00FF, "stack wrap");
    op(OP_PULL);
    rd(OFF_STK);
    chk(rdat, 32'h00C0, "stack pull wraps");
  endtask : t_stack

  task automatic t_map();
    logic [7:0] o [22] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02,
      8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h82, 8'h82, 8'h82, 8'h42, 8'h42, 8'hC2};
    logic [13:0] ad [22] = '{14'h0000, 14'h001B, 14'h001C, 14'h001F, 14'h0020, 14'h004F,
      14'h0050, 14'h00FF, 14'h0100, 14'h017F, 14'h0180, 14'h3F00, 14'h3FDF, 14'h3FEF,
      14'h3FF0, 14'h3FFF, 14'h0020, 14'h004F, 14'h0100, 14'h0020, 14'h017F, 14'h0100};
    mcr_region_t g [22] = '{MCR_IO, MCR_IO, MCR_NONE, MCR_NONE, MCR_ROM, MCR_ROM, MCR_RAM,
      MCR_RAM, MCR_ROM, MCR_ROM, MCR_ROM, MCR_SELF, MCR_OPT, MCR_SELF, MCR_VEC, MCR_VEC,
      MCR_OVL, MCR_OVL, MCR_ROM, MCR_ROM, MCR_OVL, MCR_OVL};
    for (int i = 0; i < 22; i++)
    begin
      wr(OFF_OPT, {24'h0, o[i]});
      wr(OFF_MADR, {18'h0, ad[i]});
      @(negedge mclk);
      chk({29'h0, mem_region}, {29'h0, g[i]}, "region port");
      rd(OFF_MDAT);
      chk({29'h0, rdat[10:8]}, {29'h0, g[i]}, "region read");
    end
  endtask : t_map

  task automatic t_overlay();
    wr(OFF_OPT, 32'h82);
    wr(OFF_MADR, 32'h0030);
    wr(OFF_MDAT, 32'h5A);
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, "overlay write");
    wr(OFF_OPT, 32'h02);
    wr(OFF_MDAT, 32'hA5);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "rom write");
    wr(OFF_OPT, 32'h82);
    rd(OFF_MDAT);
    chk({21'h0, rdat[10:0]}, {21'h0, MCR_OVL, 8'h5A}, "hidden ram kept");
    wr(OFF_MADR, 32'h00E0);
    wr(OFF_MDAT, 32'h3C);
    rd(OFF_MDAT);
    chk({21'h0, rdat[10:0]}, {21'h0, MCR_RAM, 8'h3C}, "user ram");
    wr(OFF_MADR, 32'h0080);
    wr(OFF_MDAT, 32'h11);
    wr(OFF_OPT, 32'hC2);
    wr(OFF_MADR, 32'h0100);
    wr(OFF_MDAT, 32'h22);
    rd(OFF_MDAT);
    chk({21'h0, rdat[10:0]}, {21'h0, MCR_OVL, 8'h22}, "high window ram");
    wr(OFF_MADR, 32'h0080);
    rd(OFF_MDAT);
    chk({21'h0, rdat[10:0]}, {21'h0, MCR_RAM, 8'h11}, "user ram not aliased");
  endtask : t_overlay

  // ****************************************************
  // Run control
  // ****************************************************
  task automatic finish_test();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    #(25 * 20000);
    mismatches++;
    finish_test();
  end

  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_irq();
    t_regs();
    t_alu();
    t_stack();
    t_map();
    t_overlay();
    finish_test();
  end
endmodule : mcr_core_tb
`default_nettype wire

// File: inc/mcr_pkg.sv
`default_nettype none
package mcr_pkg;
  // ****************************************************
  // Address space
  // ****************************************************
  localparam int ADDR_W = 14;
  localparam logic [13:0] IO_LAST = 14'h001B;
  localparam logic [13:0] UNUSED_LAST = 14'h001F;
  localparam logic [13:0] WIN0_FIRST = 14'h0020;
  localparam logic [13:0] WIN0_LAST = 14'h004F;
  localparam logic [13:0] RAM_FIRST = 14'h0050;
  localparam logic [13:0] RAM_LAST = 14'h00FF;
  localparam logic [13:0] WIN1_FIRST = 14'h0100;
  localparam logic [13:0] WIN1_LAST = 14'h017F;
  localparam logic [13:0] SELF_FIRST = 14'h3F00;
  localparam logic [13:0] SELF_LAST = 14'h3FEF;
  localparam logic [13:0] OPTION_ADDR = 14'h3FDF;
  localparam logic [13:0] VEC_FIRST = 14'h3FF0;
  localparam int OPT_LOW_BANK_BIT = 7;
  localparam int OPT_HIGH_BANK_BIT = 6;
  localparam logic [7:0] OPT_RESET = 8'h02;
  localparam int OPT_IRQ_BIT = 1;
  // ****************************************************
  // Stack and flags
  // ****************************************************
  localparam logic [7:0] STK_HIGH_FIXED = 8'h03;
  localparam logic [5:0] STK_LOW_TOP = 6'h3F;
  localparam logic [13:0] STK_RESET = 14'h00FF;
  localparam logic [4:0] CCR_RESET = 5'h08;
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;
  // ****************************************************
  // Register bus map
  // ****************************************************
  localparam logic [7:0] OFF_ACC = 8'h00;
  localparam logic [7:0] OFF_IDX = 8'h04;
  localparam logic [7:0] OFF_IP = 8'h08;
  localparam logic [7:0] OFF_STK = 8'h0C;
  localparam logic [7:0] OFF_CCR = 8'h10;
  localparam logic [7:0] OFF_OPT = 8'h14;
  localparam logic [7:0] OFF_OP = 8'h18;
  localparam logic [7:0] OFF_RES = 8'h1C;
  localparam logic [7:0] OFF_MADR = 8'h20;
  localparam logic [7:0] OFF_MDAT = 8'h24;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Operations started by writing OFF_OP
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_ADC = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_AND = 4'h3;
  localparam logic [3:0] OP_LSL = 4'h4;
  localparam logic [3:0] OP_ROR = 4'h5;
  localparam logic [3:0] OP_BTST = 4'h6;
  localparam logic [3:0] OP_SEI = 4'h7;
  localparam logic [3:0] OP_CLI = 4'h8;
  localparam logic [3:0] OP_STK_INIT = 4'h9;
  localparam logic [3:0] OP_CALL = 4'hA;
  localparam logic [3:0] OP_INTR = 4'hB;
  localparam logic [3:0] OP_PULL = 4'hC;
  localparam logic [3:0] OP_IDX = 4'hD;
  localparam logic [2:0] PUSH_CALL = 3'h2;
  localparam logic [2:0] PUSH_INTR = 3'h5;
  typedef enum logic [2:0] {
    MCR_NONE = 3'h0, MCR_IO = 3'h1, MCR_ROM = 3'h2, MCR_RAM = 3'h3,
    MCR_OVL = 3'h4, MCR_SELF = 3'h5, MCR_OPT = 3'h6, MCR_VEC = 3'h7
  } mcr_region_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } mcr_wreq_t;
endpackage : mcr_pkg
`default_nettype wire

// File: logic/mcr_core.sv
// Functional notes
// - Instruction pointer spans 16384 bytes
// - Page zero: io, window, RAM
// - Low window follows low bank select
// - High window follows high bank select
// - Overlay RAM kept while ROM selected
// - Self-check area holds option register
// - Top sixteen bytes are vectors
// - User RAM $50-$FF, stack on top
// - Eight-bit accumulator holds results
// - Eight-bit index forms effective address
// - Instruction pointer is fourteen bits
// - Stack address upper bits fixed 00000011
// - Resets and reinit load $00FF
// - Stack wraps silently past 64
// - Call pushes two, interrupt five
// - Five individually readable flags
// - Half carry from bit three
// - Mask holds off, external latched
// - Negative copies result bit seven
// - Zero flags a zero result
// - Carry from ALU, shifts, bit test
// - Four low locations stay unused
// - Bank selects at option bits 7,6
`timescale 1ns/1ps
`default_nettype none
module mcr_core
  import mcr_pkg::*;
#(
  parameter int RAM_WORDS = 384
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // AXI4-Lite write
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Interrupt pin and memory decode
  input wire logic ext_irq_n,
  output logic irq_pending,
  output mcr_region_t mem_region
);
  // ****************************************************
  // Functions
  // ****************************************************
  function automatic logic in_rng(input logic [13:0] a, input logic [13:0] lo,
                                  input logic [13:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  function automatic logic [7:0] wr8(input logic [7:0] old, input logic [31:0] d,
                                     input logic [3:0] s);
    wr8 = s[0] ? d[7:0] : old;
  endfunction : wr8

  // ****************************************************
  // State
  // ****************************************************
  logic [7:0] acc_ff, idx_ff, opt_ff;
  logic [13:0] ip_ff, madr_ff;
  logic [5:0] stk_ff;
  logic [4:0] ccr_ff;
  logic [7:0] res_ff;
  logic [7:0] ram_ff [RAM_WORDS];
  logic irq_s1_ff, irq_s2_ff, irq_prev_ff, irq_latch_ff;
  logic aw_ff, w_ff, bv_ff, rv_ff;
  mcr_wreq_t wq_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  // ****************************************************
  // Write channel capture
  // ****************************************************
  assign s_awready = !aw_ff && !bv_ff;
  assign s_wready = !w_ff && !bv_ff;
  wire aw_take = s_awvalid && s_awready;
  wire w_take = s_wvalid && s_wready;
  wire wr_go = aw_ff && w_ff && !bv_ff;
  wire [7:0] wa = wq_ff.addr;
  wire [3:0] wop = wq_ff.data[3:0];
  wire [7:0] wb = wq_ff.data[7:0];

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      wq_ff <= '0;
    end
    else
    begin
      if (aw_take)
        wq_ff.addr <= {s_awaddr[7:2], 2'b00};
      if (w_take)
      begin
        wq_ff.data <= s_wdata;
        wq_ff.strb <= s_wstrb;
      end
      aw_ff <= wr_go ? 1'b0 : (aw_ff | aw_take);
      w_ff <= wr_go ? 1'b0 : (w_ff | w_take);
    end
  end

  // ****************************************************
  // Memory decode
  // ****************************************************
  wire [13:0] ma = madr_ff;
  wire low_bank_sel = opt_ff[OPT_LOW_BANK_BIT];
  wire high_bank_sel = opt_ff[OPT_HIGH_BANK_BIT];
  wire in_w0 = in_rng(ma, WIN0_FIRST, WIN0_LAST);
  wire in_w1 = in_rng(ma, WIN1_FIRST, WIN1_LAST);
  wire ovl_sel = (in_w0 && low_bank_sel) || (in_w1 && high_bank_sel);
  wire [8:0] ram_idx = ma[8:0];
  assign mem_region =
    (ma <= IO_LAST) ? MCR_IO :
    (ma <= UNUSED_LAST) ? MCR_NONE :
    ovl_sel ? MCR_OVL :
    (in_w0 || in_w1) ? MCR_ROM :
    in_rng(ma, RAM_FIRST, RAM_LAST) ? MCR_RAM :
    (ma == OPTION_ADDR) ? MCR_OPT :
    in_rng(ma, SELF_FIRST, SELF_LAST) ? MCR_SELF :
    (ma >= VEC_FIRST) ? MCR_VEC :
    MCR_ROM;
  wire ram_hit = (mem_region == MCR_OVL) || (mem_region == MCR_RAM);
  // Own cell per address, so high window never aliases user RAM
  wire [7:0] ram_rd = ram_ff[ram_idx];

  // ****************************************************
  // ALU
  // ****************************************************
  wire cin = (wop == OP_ADC) && ccr_ff[FLG_C];
  wire [8:0] sum = {1'b0, acc_ff} + {1'b0, idx_ff} + {8'h00, cin};
  wire [4:0] hsum = {1'b0, acc_ff[3:0]} + {1'b0, idx_ff[3:0]} + {4'h0, cin};
  wire [8:0] dif = {1'b0, acc_ff} - {1'b0, idx_ff};
  wire [7:0] alu_y =
    (wop == OP_SUB) ? dif[7:0] :
    (wop == OP_AND) ? (acc_ff & idx_ff) :
    (wop == OP_LSL) ? {acc_ff[6:0], 1'b0} :
    (wop == OP_ROR) ? {ccr_ff[FLG_C], acc_ff[7:1]} :
    sum[7:0];
  wire alu_c =
    (wop == OP_SUB) ? dif[8] :
    (wop == OP_LSL) ? acc_ff[7] :
    (wop == OP_ROR) ? acc_ff[0] :
    (wop == OP_BTST) ? acc_ff[idx_ff[2:0]] :
    (wop == OP_AND) ? ccr_ff[FLG_C] :
    sum[8];
  wire is_alu = (wop <= OP_ROR);
  wire is_add = (wop == OP_ADD) || (wop == OP_ADC);
  wire [5:0] push_n = (wop == OP_CALL) ? {3'b000, PUSH_CALL} : {3'b000, PUSH_INTR};

  // ****************************************************
  // Register writes
  // ****************************************************
  wire do_op = wr_go && (wa == OFF_OP) && wq_ff.strb[0];
  wire wr_ram = wr_go && (wa == OFF_MDAT) && wq_ff.strb[0] && ram_hit;
  wire irq_fall = irq_prev_ff && !irq_s2_ff;
  wire irq_ack = do_op && (wop == OP_INTR);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      acc_ff <= 8'h00;
      idx_ff <= 8'h00;
      ip_ff <= 14'h0000;
      stk_ff <= STK_LOW_TOP;
      ccr_ff <= CCR_RESET; // Mask set
      opt_ff <= OPT_RESET; // Edge-level bit set
      madr_ff <= 14'h0000;
      res_ff <= 8'h00;
    end
    else if (wr_go)
    begin
      if (wa == OFF_ACC)
        acc_ff <= wr8(acc_ff, wq_ff.data, wq_ff.strb);
      if (wa == OFF_IDX)
        idx_ff <= wr8(idx_ff, wq_ff.data, wq_ff.strb);
      if (wa == OFF_IP && wq_ff.strb[0])
        ip_ff <= wq_ff.data[13:0];
      if (wa == OFF_STK && wq_ff.strb[0])
        stk_ff <= wq_ff.data[5:0];
      if (wa == OFF_CCR && wq_ff.strb[0])
        ccr_ff <= wq_ff.data[4:0];
      if (wa == OFF_OPT && wq_ff.strb[0])
        opt_ff <= {wb[OPT_LOW_BANK_BIT], wb[OPT_HIGH_BANK_BIT], 4'h0,
                   opt_ff[OPT_IRQ_BIT] & wb[OPT_IRQ_BIT], 1'b0};
      if (wa == OFF_MADR && wq_ff.strb[0])
        madr_ff <= wq_ff.data[13:0];
      if (do_op)
      begin
        if (is_alu)
        begin
          acc_ff <= alu_y;
          res_ff <= alu_y;
          ccr_ff[FLG_N] <= alu_y[7];
          ccr_ff[FLG_Z] <= (alu_y == 8'h00);
          ccr_ff[FLG_C] <= alu_c;
          if (is_add)
            ccr_ff[FLG_H] <= hsum[4];
        end
        case (wop)
          OP_BTST: ccr_ff[FLG_C] <= alu_c;
          OP_SEI: ccr_ff[FLG_I] <= 1'b1;
          OP_CLI: ccr_ff[FLG_I] <= 1'b0;
          OP_STK_INIT: stk_ff <= STK_LOW_TOP;
          OP_CALL, OP_INTR: stk_ff <= stk_ff - push_n;
          OP_PULL: stk_ff <= stk_ff + 6'h01;
          OP_IDX: madr_ff <= {6'h00, idx_ff};
          default: ;
        endcase
        if (wop == OP_INTR)
          ccr_ff[FLG_I] <= 1'b1;
      end
    end
  end

  // ****************************************************
  // Overlay and user RAM
  // ****************************************************
  always_ff @(posedge mclk)
  begin
    if (wr_ram)
      ram_ff[ram_idx] <= wb;
  end

  // ****************************************************
  // External interrupt latch
  // ****************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_s1_ff <= 1'b1;
      irq_s2_ff <= 1'b1;
      irq_prev_ff <= 1'b1;
      irq_latch_ff <= 1'b0;
    end
    else
    begin
      irq_s1_ff <= ext_irq_n;
      irq_s2_ff <= irq_s1_ff;
      irq_prev_ff <= irq_s2_ff;
      // Edge wins over acknowledge
      irq_latch_ff <= irq_fall | (irq_latch_ff & !irq_ack);
    end
  end
  wire lvl_irq = opt_ff[OPT_IRQ_BIT] && !irq_s2_ff;
  assign irq_pending = (irq_latch_ff || lvl_irq) && !ccr_ff[FLG_I];

  // ****************************************************
  // Write response
  // ****************************************************
  wire wa_ok = (wa <= OFF_MDAT) && !(wa == OFF_MDAT && !ram_hit);
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bv_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bv_ff <= 1'b1;
      bresp_ff <= wa_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_bready)
      bv_ff <= 1'b0;
  end
  assign s_bvalid = bv_ff;
  assign s_bresp = bresp_ff;

  // ****************************************************
  // Read channel
  // ****************************************************
  assign s_arready = !rv_ff;
  wire [7:0] ra = {s_araddr[7:2], 2'b00};
  wire [13:0] stk_addr = {STK_HIGH_FIXED, stk_ff};
  wire ra_ok = (ra <= OFF_MDAT);
  wire [31:0] rmux =
    (ra == OFF_ACC) ? {24'h0, acc_ff} :
    (ra == OFF_IDX) ? {24'h0, idx_ff} :
    (ra == OFF_IP) ? {18'h0, ip_ff} :
    (ra == OFF_STK) ? {18'h0, stk_addr} :
    (ra == OFF_CCR) ? {27'h0, ccr_ff} :
    (ra == OFF_OPT) ? {24'h0, opt_ff} :
    (ra == OFF_RES) ? {24'h0, res_ff} :
    (ra == OFF_MADR) ? {18'h0, madr_ff} :
    (ra == OFF_MDAT) ? {21'h0, mem_region, (ram_hit ? ram_rd : 8'h00)} :
    32'h0;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rv_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end
    else if (s_arvalid && s_arready)
    begin
      rv_ff <= 1'b1;
      rdata_ff <= rmux;
      rresp_ff <= ra_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_rready)
      rv_ff <= 1'b0;
  end
  assign s_rvalid = rv_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;

  // ****************************************************
  // Checks
  // ****************************************************
  property p_stk_fixed;
    @(posedge mclk) disable iff (rst)
      (s_arvalid && s_arready && ra == OFF_STK) |=> s_rdata[13:6] == STK_HIGH_FIXED;
  endproperty
  a_stk_fixed: assert property (p_stk_fixed) else $error("stack upper bits wrong");

  property p_stk_init;
    @(posedge mclk) disable iff (rst) (do_op && wop == OP_STK_INIT) |=> stk_addr == STK_RESET;
  endproperty
  a_stk_init: assert property (p_stk_init) else $error("stack reinit failed");

  property p_call;
    @(posedge mclk) disable iff (rst)
      (do_op && wop == OP_CALL) |=> stk_ff == $past(stk_ff) - 6'h02;
  endproperty
  a_call: assert property (p_call) else $error("call push count wrong");

  property p_win0;
    @(posedge mclk) disable iff (rst)
      in_w0 |-> (mem_region == (low_bank_sel ? MCR_OVL : MCR_ROM));
  endproperty
  a_win0: assert property (p_win0) else $error("low window steering wrong");

  property p_win1;
    @(posedge mclk) disable iff (rst)
      in_w1 |-> (mem_region == (high_bank_sel ? MCR_OVL : MCR_ROM));
  endproperty
  a_win1: assert property (p_win1) else $error("high window steering wrong");

  property p_zero;
    @(posedge mclk) disable iff (rst)
      (do_op && is_alu) |=> ccr_ff[FLG_Z] == (acc_ff == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_neg;
    @(posedge mclk) disable iff (rst)
      (do_op && is_alu) |=> ccr_ff[FLG_N] == acc_ff[7];
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");

  property p_mask;
    @(posedge mclk) disable iff (rst) ccr_ff[FLG_I] |-> !irq_pending;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt not held off");

  property p_latch;
    @(posedge mclk) disable iff (rst) irq_fall |=> irq_latch_ff;
  endproperty
  a_latch: assert property (p_latch) else $error("edge not latched");

  property p_unused;
    @(posedge mclk) disable iff (rst)
      (ma > IO_LAST && ma <= UNUSED_LAST) |-> mem_region == MCR_NONE;
  endproperty
  a_unused: assert property (p_unused) else $error("unused area decoded");
endmodule : mcr_core
`default_nettype wire
